//--- design/pil_pkg.sv
// package: register map, field positions, thresholds and irq numbering of the interrupt request logic
package pil_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] KEY_DATA_A    = 8'h00;
  localparam logic [7:0] KEY_EN_A      = 8'h08;
  localparam logic [7:0] KEY_CAP_A     = 8'h0C;
  localparam logic [7:0] EXP_DATA_A    = 8'h10;
  localparam logic [7:0] EXP_EN_A      = 8'h18;
  localparam logic [7:0] EXP_CAP_A     = 8'h1C;
  localparam logic [7:0] PORT_STRIDE   = 8'h10;
  localparam logic [7:0] DBG_CTRL_A    = 8'h20;
  localparam logic [7:0] DBG_DATA_A    = 8'h24;
  localparam logic [7:0] SER_CTRL_A    = 8'h28;
  localparam logic [7:0] IR_CTRL_A     = 8'h2C;
  localparam logic [7:0] TMR0_STAT_A   = 8'h30;
  localparam logic [7:0] TMR0_CTRL_A   = 8'h34;
  localparam logic [7:0] TMR_STRIDE    = 8'h08;
  localparam logic [7:0] PEND_A        = 8'h40;
  localparam logic [7:0] RST_VEC_A     = 8'h44;
  localparam logic [7:0] EXC_VEC_A     = 8'h48;
  // processor vectors
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [31:0] EXC_VECTOR   = 32'h0000_0020;
  // uart control fields
  localparam int unsigned RX_EN_BIT    = 0;
  localparam int unsigned TX_EN_BIT    = 1;
  localparam int unsigned RX_PEND_BIT  = 8;
  localparam int unsigned TX_PEND_BIT  = 9;
  localparam int unsigned CNT_LSB      = 16;
  // timer fields
  localparam int unsigned EXPIRED_BIT  = 0;
  localparam int unsigned EXP_IE_BIT   = 0;
  // request thresholds (strictly greater than)
  localparam logic [15:0] DBG_THRESH   = 16'h0007;
  localparam logic [15:0] SER_THRESH   = 16'h001F;
  localparam logic [15:0] IR_THRESH    = 16'h005F;
  // irq numbers
  localparam int unsigned IRQ_TMR0 = 0;
  localparam int unsigned IRQ_KEY  = 1;
  localparam int unsigned IRQ_TMR1 = 2;
  localparam int unsigned IRQ_AUD  = 6;
  localparam int unsigned IRQ_PS2  = 7;
  localparam int unsigned IRQ_DBG  = 8;
  localparam int unsigned IRQ_IR   = 9;
  localparam int unsigned IRQ_SER  = 10;
  localparam int unsigned IRQ_EXP  = 11;
  localparam int unsigned IRQ_USB  = 17;
  localparam int unsigned IRQ_PS2B = 23;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;
endpackage

//--- design/pil_top.sv
// interrupt request logic: parallel-port capture, uart and timer requests, irq line map, apb registers
//
// Contract
// - processor reset fetch address is 0x00000000.
// - all exceptions and interrupts vector to 0x00000020; software finds cause.
// - irq map: timer to 0, pushbutton port to 1, second timer to 2.
// - audio 6, ps2 7, debug uart 8, ir uart 9, serial 10, expansion 11, usb 17, ps2b 23.
// - parallel port per-bit interrupt enable register at offset 8.
// - capture register at offset C latches each 0-to-1 input change.
// - any write to capture register clears all bits and drops request.
// - pushbutton capture bit set on key press, readable by handler.
// - debug uart requests when enabled and fill or free count exceeds 7.
// - debug uart pending bits shown in control, clear as data moves.
// - serial uart requests when enabled and fill or free count exceeds 31.
// - serial uart pending bits shown in control, clear as data moves.
// - ir uart requests when enabled and more than 95 characters held.
// - ir uart receive pending clears as reads lower occupancy.
// - timer requests while expiry flag and expiry enable are both one.
// - any write to timer status clears the timer request.
// - all irq lines readable in a pending register.
// - expiry flag set at count zero; writing zero clears it.
// - debug uart fill count sits in data bits 31-16.
//
// Local design decision: the APB interface to the registers.
module pil_top
  import pil_pkg::*;
(
  input  wire logic        ref_clk,        // system clock
  input  wire logic        arst_n,         // async reset, active low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic             pready,         // apb ready
  output logic [31:0]      prdata,         // apb read data
  output logic             pslverr,        // apb error on unmapped address
  input  wire logic [31:0] key_in,         // pushbutton port inputs, 1 = pressed
  input  wire logic [31:0] exp_in,         // expansion port inputs
  input  wire logic [15:0] dbg_rx_fill,    // debug uart rx_fill_count
  input  wire logic [15:0] dbg_tx_free,    // debug uart tx_free_count
  input  wire logic [15:0] ser_rx_fill,    // serial uart rx_fill_count
  input  wire logic [15:0] ser_tx_free,    // serial uart tx_free_count
  input  wire logic [15:0] ir_rx_fill,     // ir uart rx_fill_count
  input  wire logic [1:0]  tmr_zero,       // timer count reached zero, one pulse each
  input  wire logic        aud_irq,        // audio port request
  input  wire logic        ps2_irq,        // ps2 port request
  input  wire logic        usb_irq,        // usb port request
  input  wire logic        ps2b_irq,       // second ps2 port request
  output logic [31:0]      irq_lines,      // processor irq inputs
  output logic [31:0]      reset_vector,   // processor reset address
  output logic [31:0]      exc_vector      // processor exception address
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address match for one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // uart request: enabled and count strictly above threshold
  // recomputed every cycle, so draining or filling a queue clears it without a write
  function automatic logic over(input logic en, input logic [15:0] cnt, input logic [15:0] th);
    over = en && (cnt > th);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // bus answer and decode
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wr_go;
  logic [31:0] rd_d;
  logic        map_d;
  // parallel port state
  logic [31:0] port_in   [2];
  logic [31:0] prev_q    [2];
  logic [31:0] en_q      [2];
  logic [31:0] cap_q     [2];
  logic [1:0]  port_irq;
  // uart state
  logic [1:0]  dbg_en_q;
  logic [1:0]  ser_en_q;
  logic        ir_en_q;
  logic [1:0]  dbg_pend_q;
  logic [1:0]  ser_pend_q;
  logic        ir_pend_q;
  // timer state
  logic [1:0]  tflag_q;
  logic [1:0]  tie_q;
  // irq and vector registers
  logic [31:0] irq_q;
  logic [31:0] irq_d;
  logic [31:0] rvec_q;
  logic [31:0] evec_q;

  // port inputs as an array for the generate loop
  assign port_in[0] = key_in;
  assign port_in[1] = exp_in;

  // a write takes effect at the edge where the master sees pready
  // reads have no side effects, so only writes need this qualifier
  assign wr_go = psel && penable && pwrite && pready_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered

  // read mux and address decode
  always_comb begin
    rd_d  = ZERO32;
    map_d = 1'b1;
    case (paddr)
      KEY_DATA_A:  rd_d = key_in;
      KEY_EN_A:    rd_d = en_q[0];
      KEY_CAP_A:   rd_d = cap_q[0];
      EXP_DATA_A:  rd_d = exp_in;
      EXP_EN_A:    rd_d = en_q[1];
      EXP_CAP_A:   rd_d = cap_q[1];
      DBG_CTRL_A:  begin
        rd_d[RX_EN_BIT]   = dbg_en_q[0];
        rd_d[TX_EN_BIT]   = dbg_en_q[1];
        rd_d[RX_PEND_BIT] = dbg_pend_q[0];
        rd_d[TX_PEND_BIT] = dbg_pend_q[1];
        rd_d[31:CNT_LSB]  = dbg_tx_free;
      end
      DBG_DATA_A:  rd_d[31:CNT_LSB] = dbg_rx_fill;
      SER_CTRL_A:  begin
        rd_d[RX_EN_BIT]   = ser_en_q[0];
        rd_d[TX_EN_BIT]   = ser_en_q[1];
        rd_d[RX_PEND_BIT] = ser_pend_q[0];
        rd_d[TX_PEND_BIT] = ser_pend_q[1];
      end
      IR_CTRL_A:   begin
        rd_d[RX_EN_BIT]   = ir_en_q;
        rd_d[RX_PEND_BIT] = ir_pend_q;
      end
      TMR0_STAT_A: rd_d[EXPIRED_BIT] = tflag_q[0];
      TMR0_CTRL_A: rd_d[EXP_IE_BIT]  = tie_q[0];
      TMR0_STAT_A + TMR_STRIDE: rd_d[EXPIRED_BIT] = tflag_q[1];
      TMR0_CTRL_A + TMR_STRIDE: rd_d[EXP_IE_BIT]  = tie_q[1];
      PEND_A:      rd_d = irq_q;
      RST_VEC_A:   rd_d = rvec_q;
      EXC_VEC_A:   rd_d = evec_q;
      default:     map_d = 1'b0;
    endcase
  end

  // ready, data and error raised one cycle into the access phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= ZERO32;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_d : ZERO32;
      pslverr_q <= psel && penable && !pready_q && !map_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel ports: enable, rising-edge capture, request

  // one instance per interrupt-capable port
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] base;
    assign base = PORT_STRIDE * 8'(p);

    // input history for edge detection
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        prev_q[p] <= ZERO32;
      end else begin
        prev_q[p] <= port_in[p];
      end
    end

    // per-bit interrupt enable
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        en_q[p] <= ZERO32;
      end else if (wr_go && hit(paddr, KEY_EN_A + base)) begin
        en_q[p] <= pwdata;
      end
    end

    // capture: any write clears, a new rising edge in the same cycle survives
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        cap_q[p] <= ZERO32;
      end else begin
        cap_q[p] <= ((wr_go && hit(paddr, KEY_CAP_A + base)) ? ZERO32 : cap_q[p])
                    | (port_in[p] & ~prev_q[p]);
      end
    end

    // request while any enabled capture bit stands
    assign port_irq[p] = |(cap_q[p] & en_q[p]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // uart interrupt enables

  // debug uart enable bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbg_en_q <= 2'b00;
    end else if (wr_go && hit(paddr, DBG_CTRL_A)) begin
      dbg_en_q <= {pwdata[TX_EN_BIT], pwdata[RX_EN_BIT]};
    end
  end

  // serial uart enable bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_en_q <= 2'b00;
    end else if (wr_go && hit(paddr, SER_CTRL_A)) begin
      ser_en_q <= {pwdata[TX_EN_BIT], pwdata[RX_EN_BIT]};
    end
  end

  // ir uart enable: no transmitter, so the transmit bits have no effect
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_en_q <= 1'b0;
    end else if (wr_go && hit(paddr, IR_CTRL_A)) begin
      ir_en_q <= pwdata[RX_EN_BIT];
    end
  end

  // debug uart pending follows the counts, so moving data clears it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbg_pend_q <= 2'b00;
    end else begin
      dbg_pend_q[0] <= over(dbg_en_q[0], dbg_rx_fill, DBG_THRESH);
      dbg_pend_q[1] <= over(dbg_en_q[1], dbg_tx_free, DBG_THRESH);
    end
  end

  // serial uart pending follows the counts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_pend_q <= 2'b00;
    end else begin
      ser_pend_q[0] <= over(ser_en_q[0], ser_rx_fill, SER_THRESH);
      ser_pend_q[1] <= over(ser_en_q[1], ser_tx_free, SER_THRESH);
    end
  end

  // ir uart receive pending follows the occupancy
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_pend_q <= 1'b0;
    end else begin
      ir_pend_q <= over(ir_en_q, ir_rx_fill, IR_THRESH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interval timers: expiry flag and expiry enable

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [7:0] toff;
    logic       st_wr;
    // register offsets of this timer
    assign toff  = TMR_STRIDE * 8'(t);
    assign st_wr = wr_go && hit(paddr, TMR0_STAT_A + toff);

    // zero reached sets; any status write clears; set wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        tflag_q[t] <= 1'b0;
      end else if (tmr_zero[t]) begin
        tflag_q[t] <= 1'b1;
      end else if (st_wr) begin
        tflag_q[t] <= 1'b0;
      end
    end

    // expiry interrupt enable
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        tie_q[t] <= 1'b0;
      end else if (wr_go && hit(paddr, TMR0_CTRL_A + toff)) begin
        tie_q[t] <= pwdata[EXP_IE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // irq line map to the processor

  // route each request to its fixed line number
  always_comb begin
    irq_d           = ZERO32;
    irq_d[IRQ_TMR0] = tflag_q[0] & tie_q[0];
    irq_d[IRQ_KEY]  = port_irq[0];
    irq_d[IRQ_TMR1] = tflag_q[1] & tie_q[1];
    irq_d[IRQ_AUD]  = aud_irq;
    irq_d[IRQ_PS2]  = ps2_irq;
    irq_d[IRQ_DBG]  = |dbg_pend_q;
    irq_d[IRQ_IR]   = ir_pend_q;
    irq_d[IRQ_SER]  = |ser_pend_q;
    irq_d[IRQ_EXP]  = port_irq[1];
    irq_d[IRQ_USB]  = usb_irq;
    irq_d[IRQ_PS2B] = ps2b_irq;
  end

  // registered irq lines, also read back as the pending register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= ZERO32;
    end else begin
      irq_q <= irq_d;
    end
  end

  // fixed vectors held in flip-flops so the outputs come from registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvec_q <= RESET_VECTOR;
      evec_q <= EXC_VECTOR;
    end else begin
      rvec_q <= RESET_VECTOR;
      evec_q <= EXC_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign irq_lines    = irq_q;
  assign reset_vector = rvec_q;
  assign exc_vector   = evec_q;

endmodule

//--- tb/pil_top_asserts.sv
// checker: port assertions of the interrupt request logic
module pil_top_asserts
  import pil_pkg::*;
(
  input wire logic        ref_clk,      // clock
  input wire logic        arst_n,       // reset
  input wire logic        psel,         // select
  input wire logic        penable,      // access
  input wire logic        pready,       // ready
  input wire logic [31:0] prdata,       // read data
  input wire logic        pslverr,      // error
  input wire logic [15:0] ser_rx_fill,  // serial fill
  input wire logic [15:0] ser_tx_free,  // serial free
  input wire logic [31:0] irq_lines,    // irq lines
  input wire logic [31:0] reset_vector, // reset address
  input wire logic [31:0] exc_vector    // exception address
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // bus request and answer steps, and serial counts at or below threshold
  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready;
  endsequence
  sequence s_ser_low;
    ser_rx_fill <= SER_THRESH && ser_tx_free <= SER_THRESH;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_rst_vec: assert property (reset_vector == RESET_VECTOR)
    else $error("reset vector wrong");
  a_exc_vec: assert property (exc_vector == EXC_VECTOR)
    else $error("exception vector wrong");
  a_ready_next: assert property (s_req |=> s_ans)
    else $error("no answer after access");
  a_ready_pulse: assert property (s_ans |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (s_ans |-> $past(psel && penable))
    else $error("ready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == ZERO32)
    else $error("read data outside answer");
  a_unused_irq: assert property ((irq_lines & 32'hFF7D_F038) == ZERO32)
    else $error("unassigned irq line high");
  a_ser_quiet: assert property (s_ser_low [*2] |=> !irq_lines[IRQ_SER])
    else $error("serial request below threshold");
endmodule
bind pil_top pil_top_asserts pil_top_asserts_i (.*);

//--- tb/pil_cpu_model.sv
// processor core model: pending register and next fetch address
module pil_cpu_model
  import pil_pkg::*;
(
  input  wire logic        ref_clk,      // clock
  input  wire logic        arst_n,       // reset
  input  wire logic [31:0] irq_lines,    // irq inputs
  input  wire logic [31:0] reset_vector, // reset address
  input  wire logic [31:0] exc_vector,   // exception address
  output logic [31:0]      pend_q,       // pending register
  output logic [31:0]      vec_q         // fetch address
);
  timeunit 1ns;
  timeprecision 1ps;
  // latch requests; any request sends the core to the shared vector
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= ZERO32;
      vec_q  <= ZERO32;
    end else begin
      pend_q <= irq_lines;
      vec_q  <= (|irq_lines) ? exc_vector : reset_vector;
    end
  end
endmodule

//--- tb/pil_top_tb.sv
// self-checking bench of the interrupt request logic
module pil_top_tb
  import pil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  CA[3] = '{DBG_CTRL_A, SER_CTRL_A, IR_CTRL_A};
  localparam logic [15:0] TH[3] = '{DBG_THRESH, SER_THRESH, IR_THRESH};
  localparam int          IQ[3] = '{IRQ_DBG, IRQ_SER, IRQ_IR};
  localparam int          LN[4] = '{IRQ_AUD, IRQ_PS2, IRQ_USB, IRQ_PS2B};
  logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        aud_irq, ps2_irq, usb_irq, ps2b_irq;
  logic [1:0]  tmr_zero;
  logic [7:0]  paddr, a;
  logic [15:0] dbg_rx_fill, dbg_tx_free, ser_rx_fill, ser_tx_free, ir_rx_fill;
  logic [31:0] pwdata, prdata, key_in, exp_in, irq_lines, reset_vector, exc_vector;
  logic [31:0] pend_q, vec_q, rd, m, v, w, seed;
  int          n_fail, n_tests;
  pil_top       pil_top_i (.*);
  pil_cpu_model pil_cpu_model_i (.*);
  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] rise(logic [31:0] o, logic [31:0] n);
    return ~o & n;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer held until pready, then one idle cycle
  task automatic apb(logic wr, logic [7:0] ad, logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(logic [7:0] ad, logic [31:0] e, logic er = 1'b0);
    apb(1'b0, ad, ZERO32);
    chk(rd, e);
    chk(32'(err), 32'(er));
  endtask
  task automatic ick(int n, logic e);
    chk(32'(irq_lines[n]), 32'(e));
  endtask
  task automatic upc(logic [7:0] ad, int b, int n, logic e);
    apb(1'b0, ad, ZERO32);
    chk(32'(rd[b]), 32'(e));
    ick(n, e);
  endtask
  task automatic setc(int u, int d, logic [15:0] c);
    case (u * 2 + d)
      0: dbg_rx_fill <= c;
      1: dbg_tx_free <= c;
      2: ser_rx_fill <= c;
      3: ser_tx_free <= c;
      default: ir_rx_fill <= c;
    endcase
    tick(3);
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h0001_4B45;
    {n_fail, n_tests} = '0;
    {arst_n, psel, penable, pwrite, paddr, pwdata, key_in, exp_in, tmr_zero} = '0;
    {aud_irq, ps2_irq, usb_irq, ps2b_irq, dbg_rx_fill, dbg_tx_free} = '0;
    {ser_rx_fill, ser_tx_free, ir_rx_fill} = '0;
    tick(3);
    chk(reset_vector, RESET_VECTOR);
    chk(exc_vector, EXC_VECTOR);
    chk(irq_lines, ZERO32);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(RST_VEC_A, RESET_VECTOR);
    rdc(EXC_VEC_A, EXC_VECTOR);
    rdc(8'h4C, ZERO32, 1'b1);
    // parallel ports: rises, accumulation, masking, clear on write
    for (int p = 0; p < 2; p++) begin
      a = KEY_DATA_A + 8'(p) * PORT_STRIDE;
      m = rnd();
      v = rnd();
      w = rnd();
      apb(1'b1, a + 8'h08, m);
      if (p == 0) key_in <= v;
      else exp_in <= v;
      tick(4);
      rdc(a + 8'h0C, v);
      if (p == 0) key_in <= w;
      else exp_in <= w;
      tick(4);
      rdc(a + 8'h0C, v | rise(v, w));
      ick(p ? IRQ_EXP : IRQ_KEY, |((v | rise(v, w)) & m));
      apb(1'b1, a + 8'h08, ZERO32);
      tick(3);
      ick(p ? IRQ_EXP : IRQ_KEY, 1'b0);
      apb(1'b1, a + 8'h0C, rnd());
      rdc(a + 8'h0C, ZERO32);
    end
    // uart thresholds: enable off, on, then back at the limit
    for (int u = 0; u < 3; u++) begin
      for (int d = 0; d < (u < 2 ? 2 : 1); d++) begin
        apb(1'b1, CA[u], ZERO32);
        setc(u, d, TH[u] + 16'h1);
        upc(CA[u], RX_PEND_BIT + d, IQ[u], 1'b0);
        apb(1'b1, CA[u], u < 2 ? 32'h3 : 32'h1);
        tick(3);
        upc(CA[u], RX_PEND_BIT + d, IQ[u], 1'b1);
        setc(u, d, TH[u]);
        upc(CA[u], RX_PEND_BIT + d, IQ[u], 1'b0);
      end
    end
    apb(1'b0, DBG_DATA_A, ZERO32);
    chk(32'(rd[31:16]), 32'(DBG_THRESH));
    // timers: flag, request, clear by any write
    for (int t = 0; t < 2; t++) begin
      a = TMR0_STAT_A + 8'(t) * TMR_STRIDE;
      apb(1'b1, a + 8'h04, 32'h1);
      tmr_zero[t] <= 1'b1;
      @(posedge ref_clk);
      tmr_zero[t] <= 1'b0;
      tick(3);
      rdc(a, 32'h1);
      ick(t ? IRQ_TMR1 : IRQ_TMR0, 1'b1);
      rdc(PEND_A, 32'h1 << (t ? IRQ_TMR1 : IRQ_TMR0));
      chk(pend_q, 32'h1 << (t ? IRQ_TMR1 : IRQ_TMR0));
      chk(vec_q, EXC_VECTOR);
      apb(1'b1, a, t ? rnd() : ZERO32);
      tick(3);
      rdc(a, ZERO32);
      ick(t ? IRQ_TMR1 : IRQ_TMR0, 1'b0);
    end
    // external request lines
    {aud_irq, ps2_irq, usb_irq, ps2b_irq} <= 4'hF;
    tick(3);
    rdc(PEND_A, 32'h0082_00C0);
    // one line at a time, so a swapped pair of lines shows
    for (int i = 0; i < 4; i++) begin
      {aud_irq, ps2_irq, usb_irq, ps2b_irq} <= 4'h8 >> i;
      tick(3);
      rdc(PEND_A, 32'h1 << LN[i]);
    end
    {aud_irq, ps2_irq, usb_irq, ps2b_irq} <= 4'h0;
    tick(4);
    chk(vec_q, RESET_VECTOR);
    // reset in mid-run: vectors and lines at reset values, enables cleared
    arst_n <= 1'b0;
    tick(2);
    chk(reset_vector, RESET_VECTOR);
    chk(exc_vector, EXC_VECTOR);
    chk(irq_lines, ZERO32);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(TMR0_CTRL_A, ZERO32);
    rdc(KEY_EN_A, ZERO32);
    end_sim();
  end
  // watchdog
  initial begin
    tick(5000);
    n_fail++;
    end_sim();
  end
endmodule
